// File: core/acc_add_consts.svh
// How it works
// RL1 - Add-immediate adds the next byte; two bytes, two machine cycles.
// RL2 - Add-register adds the working register 0 to 7 that the opcode picks.
// RL3 - Indirect add points via register 0 or 1; bits 0-5 pick a RAM byte.
// RL4 - Add-with-carry-immediate adds the data byte plus the carry flag.
// RL5 - Half carry is carry out of bit 3, carry is carry out of bit 7.
`ifndef ACC_ADD_CONSTS_SVH
`define ACC_ADD_CONSTS_SVH

// ----------------------------------------
// Opcodes
// ----------------------------------------
`define OP_ADD_IMM      8'h03
`define OP_ADD_WITH_CARRY_OP_IMM     8'h13
`define OP_ADD_REG_HI   5'h0d
`define OP_ADD_IND_HI   7'h30
`define ACC_RESET       8'h00
`define RAM_ADDR_W      6

// ----------------------------------------
// Field positions
// ----------------------------------------
`define OPC_REG_MSB     7
`define OPC_REG_LSB     3
`define OPC_IND_LSB     1
`define REG_IDX_MSB     2
`define PTR_IDX_BIT     0
`define RAM_ADDR_MSB    5
`define SUM_HALF_BIT    8
`define SUM_CARRY_BIT   9

`endif

// File: core/acc_add_pkg.sv
package acc_add_pkg;
	typedef enum logic [1:0] {
		ST_FETCH,
		ST_IMM
	} state_e;
endpackage : acc_add_pkg

// File: core/accumulator_add_datapath.sv
`timescale 1ns/1ps
`include "acc_add_consts.svh"

module accumulator_add_datapath (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rstn,
	// Instruction byte stream, one byte per machine cycle
	input  wire logic       byte_valid,
	input  wire logic [7:0] byte_data,
	// Working register bank read
	output logic [2:0]      working_register_sel,
	input  wire logic [7:0] reg_rdata,
	// Internal data RAM read
	output logic [5:0]      ram_addr,
	input  wire logic [7:0] ram_rdata,
	// Program status word flags, accumulator and immediate busy
	output logic [7:0]      acc,
	output logic            carry_flag,
	output logic            half_carry_flag,
	output logic            busy
);

	// ----------------------------------------
	// Timing notes
	// ----------------------------------------
	// One byte is taken per rising edge while byte_valid is high.
	// Register and indirect forms finish on the edge that takes the
	// opcode, so the bank and the RAM must answer in the same cycle;
	// a registered RAM would need an extra wait state here.
	// Immediate forms take the opcode on one edge and the data byte on
	// a later one; busy marks the gap, and any byte taken while busy
	// is data, even one that looks like an opcode.
	// Bytes that are no add form are ignored, so the rest of the
	// instruction set can share the same byte stream.

	// ----------------------------------------
	// Adder shared by every add form
	// ----------------------------------------
	function automatic logic [9:0] add8(input logic [7:0] a,
		input logic [7:0] b, input logic cin);
		logic [4:0] lo;
		logic [4:0] hi;
		lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
		return {hi[4], lo[4], hi[3:0], lo[3:0]}; // RL5
	endfunction : add8

	// ----------------------------------------
	// Opcode decode, shared by datapath and checks
	// ----------------------------------------
	// Register form: upper five bits fixed, low three pick the register
	function automatic logic dec_add_reg(input logic [7:0] op);
		return op[`OPC_REG_MSB:`OPC_REG_LSB] == `OP_ADD_REG_HI; // RL2
	endfunction : dec_add_reg

	// Indirect form has two codes only, hence two pointer registers
	function automatic logic dec_add_ind(input logic [7:0] op);
		return op[`OPC_REG_MSB:`OPC_IND_LSB] == `OP_ADD_IND_HI; // RL3
	endfunction : dec_add_ind

	// Either two-byte immediate form
	function automatic logic dec_add_imm(input logic [7:0] op);
		return op == `OP_ADD_IMM || op == `OP_ADD_WITH_CARRY_OP_IMM; // RL1 RL4
	endfunction : dec_add_imm

	acc_add_pkg::state_e state_reg;
	logic                with_carry_reg;
	logic [7:0]          operand;
	logic                do_add;
	logic                cin;
	logic [9:0]          sum;
	logic                is_reg;
	logic                is_ind;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	// Register read index comes straight from the opcode
	assign is_reg = dec_add_reg(byte_data);                // RL2
	assign is_ind = dec_add_ind(byte_data);                // RL3
	// Pointer index keeps only the low opcode bit
	assign working_register_sel = is_ind
		? {2'h0, byte_data[`PTR_IDX_BIT]}
		: byte_data[`REG_IDX_MSB:0];                     // RL2 RL3
	// Upper two pointer bits are ignored: RAM is 64 bytes
	assign ram_addr = reg_rdata[`RAM_ADDR_MSB:0];          // RL3
	assign busy = state_reg == acc_add_pkg::ST_IMM;

	// ----------------------------------------
	// Operand select
	// ----------------------------------------
	// Pick operand and carry-in; the wait for data has priority
	// because a data byte may alias any opcode
	always_comb begin
		do_add  = 1'b0;
		operand = reg_rdata;
		cin     = 1'b0;
		if (byte_valid && state_reg == acc_add_pkg::ST_IMM) begin
			do_add  = 1'b1;
			operand = byte_data;                           // RL1
			cin     = with_carry_reg & carry_flag;         // RL4
		end else if (byte_valid && is_reg) begin
			do_add = 1'b1;
		end else if (byte_valid && is_ind) begin
			do_add  = 1'b1;
			operand = ram_rdata;
		end
	end
	assign sum = add8(acc, operand, cin);

	// ----------------------------------------
	// Immediate sequencing
	// ----------------------------------------
	// Two-cycle immediate forms wait for the data byte
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_reg      <= acc_add_pkg::ST_FETCH;
			with_carry_reg <= 1'b0;
		end else if (byte_valid) begin
			if (state_reg == acc_add_pkg::ST_IMM) begin
				state_reg <= acc_add_pkg::ST_FETCH;
			end else if (dec_add_imm(byte_data)) begin
				state_reg      <= acc_add_pkg::ST_IMM;   // RL1
				with_carry_reg <= byte_data == `OP_ADD_WITH_CARRY_OP_IMM;
			end
		end
	end

	// ----------------------------------------
	// Accumulator update
	// ----------------------------------------
	// Accumulator and both carries; flags always follow the last add
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			acc             <= `ACC_RESET;
			carry_flag      <= 1'b0;
			half_carry_flag <= 1'b0;
		end else if (do_add) begin
			acc             <= sum[7:0];
			half_carry_flag <= sum[`SUM_HALF_BIT];         // RL5
			carry_flag      <= sum[`SUM_CARRY_BIT];        // RL5
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	// Opcode of an immediate form must open the wait for its data
	chk_imm_two_cycle: assert property ( // RL1
		@(posedge clk) disable iff (!rstn)
		byte_valid && !busy && dec_add_imm(byte_data) |=> busy)
		else $error("immediate add did not wait for data");

	// A data byte always ends the wait, whatever its value
	chk_imm_ends_wait: assert property ( // RL1
		@(posedge clk) disable iff (!rstn)
		byte_valid && busy |=> !busy)
		else $error("immediate wait did not end on data byte");

	// Register form adds the selected bank entry
	chk_reg_sum: assert property ( // RL2
		@(posedge clk) disable iff (!rstn)
		byte_valid && !busy && is_reg
		|=> acc == 8'($past(acc) + $past(reg_rdata)))
		else $error("register add result wrong");

	// Indirect form adds the RAM byte the pointer names
	chk_ind_sum: assert property ( // RL3
		@(posedge clk) disable iff (!rstn)
		byte_valid && !busy && is_ind
		|=> acc == 8'($past(acc) + $past(ram_rdata)))
		else $error("indirect add result wrong");

	// Indirect pointer is limited to the two lowest registers
	chk_ptr_range: assert property ( // RL3
		@(posedge clk) disable iff (!rstn)
		byte_valid && !busy && is_ind
		|-> working_register_sel[`REG_IDX_MSB:1] == 2'h0)
		else $error("indirect pointer outside register 0 or 1");

	// Add with carry folds the old carry into the sum
	chk_add_with_carry_op_sum: assert property ( // RL4
		@(posedge clk) disable iff (!rstn)
		byte_valid && busy && with_carry_reg
		|=> acc == 8'($past(acc) + $past(byte_data)
		+ 8'($past(carry_flag))))
		else $error("add with carry result wrong");

	// Carry of the add with carry, worked out at nine bits
	chk_add_with_carry_op_carry: assert property ( // RL4
		@(posedge clk) disable iff (!rstn)
		byte_valid && busy && with_carry_reg
		|=> carry_flag == (({1'b0, $past(acc)} + {1'b0, $past(byte_data)}
		+ {8'h00, $past(carry_flag)}) > 9'h0ff))
		else $error("add with carry flag wrong");

	// Both carries follow the nibble and byte carries of the sum
	chk_carry_out: assert property ( // RL5
		@(posedge clk) disable iff (!rstn)
		do_add |=> carry_flag == $past(sum[`SUM_CARRY_BIT]) &&
		half_carry_flag == ((($past(acc[3:0]) + $past(operand[3:0])
		+ 4'($past(cin))) & 5'h10) != 5'h0))
		else $error("carry flags wrong");

	// Plain immediate carry, independent of the shared adder
	chk_imm_carry: assert property ( // RL5
		@(posedge clk) disable iff (!rstn)
		byte_valid && busy && !with_carry_reg
		|=> carry_flag == (({1'b0, $past(acc)}
		+ {1'b0, $past(byte_data)}) > 9'h0ff))
		else $error("immediate add carry wrong");

	// Bytes that are no add form leave the datapath alone
	chk_other_ignored: assert property (
		@(posedge clk) disable iff (!rstn)
		byte_valid && !busy && !is_reg && !is_ind
		&& !dec_add_imm(byte_data)
		|=> $stable(acc) && $stable(carry_flag) && !busy)
		else $error("non-add byte changed the datapath");

	// Without a valid byte nothing may move
	chk_idle_hold: assert property (
		@(posedge clk) disable iff (!rstn)
		!byte_valid |=> $stable(acc) && $stable(carry_flag)
		&& $stable(half_carry_flag) && $stable(busy))
		else $error("state moved without a valid byte");

	// ----------------------------------------
	// Coverage
	// ----------------------------------------
	// Plain immediate add finishing
	cov_add_imm: cover property (@(posedge clk)
		byte_valid && busy && !with_carry_reg);
	// Add with carry while the carry is set
	cov_add_with_carry_op_carry: cover property (@(posedge clk)
		byte_valid && busy && with_carry_reg && carry_flag);
	// Indirect add through a pointer
	cov_ind: cover property (@(posedge clk) byte_valid && !busy && is_ind);
	// Register add
	cov_reg: cover property (@(posedge clk) byte_valid && !busy && is_reg);
	// Stream pauses between opcode and data byte
	cov_imm_gap: cover property (@(posedge clk) busy && !byte_valid);

endmodule : accumulator_add_datapath

// File: dv/accumulator_add_datapath_bench.sv
`timescale 1ns/1ps
module accumulator_add_datapath_bench;
	// ----------------
	// Stimulus and model
	// ----------------
	logic        clk = 0, rstn = 0, byte_valid = 0, c = 0, h = 0;
	logic [7:0]  byte_data = 8'h00, a = 8'h00, acc, rf [8], ram [64];
	logic [2:0]  working_register_sel;
	logic [5:0]  ram_addr;
	logic        carry_flag, half_carry_flag, busy;
	logic [8:0]  s;
	logic [15:0] rows [9] = '{16'h03ff, 16'h0301, 16'h1300, 16'h13ff,
		16'h1388, 16'h6800, 16'h6f00, 16'h6000, 16'h6100};
	int          fail_count = 0, n_tests = 0;
	// Bank and RAM answer in the same cycle, as the core expects
	wire  [7:0]  reg_rdata = rf[working_register_sel];
	wire  [7:0]  ram_rdata = ram[ram_addr];
	accumulator_add_datapath dut (.clk, .rstn, .byte_valid, .byte_data,
		.working_register_sel, .reg_rdata, .ram_addr, .ram_rdata,
		.acc, .carry_flag, .half_carry_flag, .busy);
	always #2 clk = ~clk;
	task automatic chk(input logic [10:0] got, input logic [10:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : tally_and_finish
	// Called at a falling edge; leaves valid high so ops run back to back
	task automatic op(input logic [7:0] o, input logic [7:0] d);
		logic [7:0] b;
		logic       ci;
		ci = o[4] & c;
		b = o[3] ? rf[o[2:0]] : (o[6] ? ram[rf[o[0]][5:0]] : d);
		s = a + b + ci;
		h = ({1'b0, a[3:0]} + b[3:0] + ci) > 5'h0f;
		c = s[8];
		a = s[7:0];
		byte_data = o;
		byte_valid = 1;
		@(negedge clk);
		if (!o[3] && !o[6]) begin
			chk({10'h000, busy}, 11'h001);
			byte_data = d;
			@(negedge clk);
		end
		chk({busy, carry_flag, half_carry_flag, acc}, {1'b0, c, h, a});
	endtask : op
	// ----------------
	// Watchdog: whole run is about 30 cycles, limit is 5000
	// ----------------
	initial begin
		#20000;
		fail_count++;
		tally_and_finish();
	end
	initial begin
		for (int i = 0; i < 8; i++) rf[i] = 8'(8'hc5 + 8'h2b * i);
		for (int j = 0; j < 64; j++) ram[j] = 8'(8'h37 * j + 8'h09);
		repeat (6) @(negedge clk);
		chk({busy, carry_flag, half_carry_flag, acc}, 11'h000);
		rstn = 1;
		@(negedge clk);
		foreach (rows[k]) op(rows[k][15:8], rows[k][7:0]);
		// Non-add and illegal pointer register must leave state alone
		byte_data = 8'h62;
		@(negedge clk);
		byte_data = 8'h27;
		@(negedge clk);
		chk({busy, carry_flag, half_carry_flag, acc}, {1'b0, c, h, a});
		op(8'h03, 8'h0f);
		// Reset in mid-run clears accumulator and flags
		rstn = 0;
		byte_valid = 0;
		@(negedge clk);
		chk({busy, carry_flag, half_carry_flag, acc}, 11'h000);
		{a, c, h} = 10'h000;
		rstn = 1;
		@(negedge clk);
		op(8'h13, 8'h7f);
		byte_valid = 0;
		tally_and_finish();
	end
endmodule : accumulator_add_datapath_bench
